// [hdl/dsl_map.svh]
// Purpose: Register offsets, reset values, field positions and timing for the status/load block
// Assumes: 8-bit register addresses and data, 125 MHz register clock
// Notes:   Definitions only
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH
`define DSL_ADDR_STATUS 8'hC2
`define DSL_ADDR_HW_LOAD 8'hD0
`define DSL_RST_STATUS 8'h04
`define DSL_RST_HW_LOAD 8'hFF
`define DSL_STATUS_W1C_MASK 8'h0E
`define DSL_BIT_UPD_ERR 3
`define DSL_BIT_RST_WARN 2
`define DSL_BIT_IF_ERR 1
`define DSL_CLK_PERIOD_PS 8000
`define DSL_UPD_GAP_PS 640000
// Least time rounds up to whole cycles
`define DSL_UPD_GAP_CYC ((`DSL_UPD_GAP_PS + `DSL_CLK_PERIOD_PS - 1) / `DSL_CLK_PERIOD_PS)
`define DSL_GAP_W 7
`define DSL_ZERO8 8'h00
`endif

// [hdl/dsl_pkg.sv]
// Purpose: Shared types for the status/load block
// Assumes: Eight channels
// Notes:   Constants live in dsl_map.svh
package dsl_pkg;
   typedef logic [7:0] dsl_byte_t;
   typedef logic [15:0] dsl_code_t;
   typedef enum logic [1:0]
   {
      DSL_GAP_IDLE = 2'b01,
      DSL_GAP_BUSY = 2'b10
   } dsl_gap_state_t;
endpackage

// [hdl/dsl_load_if.sv]
// Purpose: Carries the per-channel load request between top and load stage
// Assumes: One clock
// Notes:   None
`timescale 1ns/100ps
interface dsl_load_if;
   logic strobe;
   dsl_pkg::dsl_byte_t enable;
   dsl_pkg::dsl_byte_t update;
   modport ctrl (output strobe, output enable, input update);
   modport stage (input strobe, input enable, output update);
endinterface

// [hdl/dsl_load_stage.sv]
// Purpose: Moves pending channel codes to the outputs on a gated load strobe
// Assumes: Load strobe synchronous to clk_i
// Notes:   One update pulse per channel moved
`timescale 1ns/100ps
`include "dsl_map.svh"
module dsl_load_stage
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   dsl_load_if.stage ld,
   // Channel codes
   input wire logic [127:0] pending_code_i,
   output logic [127:0] output_code_o
);
   // ****************************************************
   // Gated transfer
   // ****************************************************
   wire logic [7:0] take = ld.strobe ? ld.enable : `DSL_ZERO8;
   assign ld.update = take;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         output_code_o <= '0;
      else
         for (int i = 0; i < 8; i++)
            if (take[i])
               output_code_o[i*16 +: 16] <= pending_code_i[i*16 +: 16];
   end
endmodule

// [hdl/dsl_top.sv]
// Purpose: Status flag register and hardware load enable mask of an eight-channel converter
// Assumes: Register port strobes synchronous to clk_i, one access per strobe
// Notes:   Read data is registered, valid one cycle after the read strobe
// How it works
// - Status register at 0xC2, resets to 0x04, bits 7:4 and 0 read zero.
// - Host reads flags; writing one clears a flag, zero leaves it.
// - Bit 3 sets when an update comes under 640 ns after the last.
// - Bit 2 sets on every reset and holds until cleared.
// - Bit 1 sets while any serial interface error flag is high.
// - Load mask at 0xD0, read/write, resets to 0xFF.
// - Mask bit n enables hardware load for channel n; zero disables it.
`timescale 1ns/100ps
`include "dsl_map.svh"
module dsl_top
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Event sources
   input wire logic [7:0] if_err_flags_i,
   input wire logic [7:0] chan_update_i,
   // Load pin and channel data
   input wire logic output_load_strobe_i,
   input wire logic [127:0] channel_code_register_i,
   output logic [127:0] output_code_o,
   output logic [7:0] hw_load_enable_chan_o
);
   // ****************************************************
   // Register state
   // ****************************************************
   // Flag, mask and read data registers
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] set_bits;
   logic [7:0] mask_q;
   logic [7:0] mask_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   // Update spacing counter
   logic [`DSL_GAP_W-1:0] gap_q;
   logic [`DSL_GAP_W-1:0] gap_d;
   dsl_pkg::dsl_gap_state_t gap_st_q;
   dsl_pkg::dsl_gap_state_t gap_st_d;
   // Link to the load stage
   dsl_load_if ld ();

   // ****************************************************
   // Helper functions
   // ****************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   // One flag bit; a set in the same cycle as its clear wins, so no event is lost
   function automatic logic flag_next(input logic cur, input logic clr_b, input logic set_b);
      flag_next = (cur & ~clr_b) | set_b;
   endfunction

   // ****************************************************
   // Address decode
   // ****************************************************
   wire logic sel_status = hit(reg_addr_i, `DSL_ADDR_STATUS);
   wire logic sel_mask = hit(reg_addr_i, `DSL_ADDR_HW_LOAD);
   wire logic wr_status = reg_wr_i & sel_status;
   wire logic wr_mask = reg_wr_i & sel_mask;
   wire logic rd_status = reg_rd_i & sel_status;
   wire logic rd_mask = reg_rd_i & sel_mask;

   // Writing zero leaves a flag alone; only the three flag bits can be cleared
   wire logic [7:0] clr_bits = wr_status ? (reg_wdata_i & `DSL_STATUS_W1C_MASK)
                                         : `DSL_ZERO8;

   // ****************************************************
   // Update events
   // ****************************************************
   // Register-side updates and hardware loads both count as output updates
   wire logic chan_upd = |chan_update_i;
   wire logic load_upd = |ld.update;
   wire logic any_update = chan_upd | load_upd;

   // ****************************************************
   // Update spacing
   // ****************************************************
   // gap_q counts cycles since the last update, from one; an update 80 cycles
   // on is legal, so the busy window ends after count 79
   wire logic gap_busy = (gap_st_q == dsl_pkg::DSL_GAP_BUSY);
   wire logic gap_last = (gap_q == `DSL_GAP_W'(`DSL_UPD_GAP_CYC - 1));
   wire logic upd_err = any_update & gap_busy;

   always_comb
   begin
      gap_st_d = gap_st_q;
      gap_d = gap_q;
      if (any_update)
      begin
         gap_st_d = dsl_pkg::DSL_GAP_BUSY;
         gap_d = `DSL_GAP_W'(1);
      end
      else
      begin
         case (gap_st_q)
            dsl_pkg::DSL_GAP_BUSY:
            begin
               gap_d = gap_q + `DSL_GAP_W'(1);
               if (gap_last)
                  gap_st_d = dsl_pkg::DSL_GAP_IDLE;
            end
            dsl_pkg::DSL_GAP_IDLE:
               gap_st_d = dsl_pkg::DSL_GAP_IDLE;
            default:
               gap_st_d = dsl_pkg::DSL_GAP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         gap_st_q <= dsl_pkg::DSL_GAP_IDLE;
         gap_q <= '0;
      end
      else
      begin
         gap_st_q <= gap_st_d;
         gap_q <= gap_d;
      end
   end

   // ****************************************************
   // Flag sources
   // ****************************************************
   // Interface errors are levels; the flag keeps being set while any stays high
   wire logic if_err_any = |if_err_flags_i;

   always_comb
   begin
      set_bits = `DSL_ZERO8;
      set_bits[`DSL_BIT_UPD_ERR] = upd_err;
      set_bits[`DSL_BIT_IF_ERR] = if_err_any;
   end

   // ****************************************************
   // Status flags
   // ****************************************************
   // The reset warning has no set source: only reset raises it
   always_comb
   begin
      status_d = `DSL_ZERO8;
      status_d[`DSL_BIT_UPD_ERR] = flag_next(status_q[`DSL_BIT_UPD_ERR],
                                             clr_bits[`DSL_BIT_UPD_ERR],
                                             set_bits[`DSL_BIT_UPD_ERR]);
      status_d[`DSL_BIT_RST_WARN] = flag_next(status_q[`DSL_BIT_RST_WARN],
                                              clr_bits[`DSL_BIT_RST_WARN],
                                              set_bits[`DSL_BIT_RST_WARN]);
      status_d[`DSL_BIT_IF_ERR] = flag_next(status_q[`DSL_BIT_IF_ERR],
                                            clr_bits[`DSL_BIT_IF_ERR],
                                            set_bits[`DSL_BIT_IF_ERR]);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_q <= `DSL_RST_STATUS;
      else
         status_q <= status_d;
   end

   // ****************************************************
   // Load mask
   // ****************************************************
   // A write takes effect on the next cycle
   assign mask_d = wr_mask ? reg_wdata_i : mask_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mask_q <= `DSL_RST_HW_LOAD;
      else
         mask_q <= mask_d;
   end

   // ****************************************************
   // Read path
   // ****************************************************
   // Unmapped addresses and reserved bits read as zero
   wire logic [7:0] rd_sel = rd_status ? status_q :
                             rd_mask ? mask_q : `DSL_ZERO8;
   assign rdata_d = reg_rd_i ? rd_sel : rdata_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_q <= `DSL_ZERO8;
      else
         rdata_q <= rdata_d;
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign reg_rdata_o = rdata_q;
   assign hw_load_enable_chan_o = mask_q;

   // ****************************************************
   // Hardware load
   // ****************************************************
   // Only channels enabled in the mask follow the load pin
   assign ld.strobe = output_load_strobe_i;
   assign ld.enable = mask_q;

   dsl_load_stage u_stage
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ld(ld),
      .pending_code_i(channel_code_register_i),
      .output_code_o(output_code_o)
   );
endmodule

// [test/dsl_host_model.sv]
// Purpose: Host side of the register port
// Assumes: Strobes taken at the next rising edge
// Notes: Released lines show the inverse of their last value
`timescale 1ns/100ps
module dsl_host_model
(
   // Clock and read data
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   // Request
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00,
   output logic wr_o = 1'b0,
   output logic rd_o = 1'b0
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i) wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i) rd_o <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i) d = rdata_i;
   endtask
endmodule

// [test/dsl_top_monitor.sv]
// Purpose: Port checks of dsl_top
// Assumes: One clock, synchronous reset
// Notes: Bound after the module
`timescale 1ns/100ps
module dsl_top_monitor
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Event sources and load
   input wire logic [7:0] if_err_flags_i,
   input wire logic output_load_strobe_i,
   input wire logic [127:0] channel_code_register_i,
   input wire logic [127:0] output_code_o,
   input wire logic [7:0] hw_load_enable_chan_o
);
   wire rs = reg_rd_i && reg_addr_i == 8'hC2;
   wire rm = reg_rd_i && reg_addr_i == 8'hD0;
   wire ws = reg_wr_i && reg_addr_i == 8'hC2;
   wire wm = reg_wr_i && reg_addr_i == 8'hD0;
   wire e = |if_err_flags_i;
   logic [127:0] en;
   always_comb
      for (int i = 0; i < 8; i++)
         en[16*i+:16] = {16{hw_load_enable_chan_o[i]}};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   resv_zero_a: assert property (rs |=> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[0])
      else $error("reserved status bit set");
   unmap_zero_a: assert property (reg_rd_i && !rs && !rm |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   mask_write_a: assert property (wm |=> hw_load_enable_chan_o == $past(reg_wdata_i))
      else $error("mask write lost");
   mask_read_a: assert property (rm |=> reg_rdata_o == $past(hw_load_enable_chan_o))
      else $error("mask read wrong");
   mask_hold_a: assert property (!wm |=> $stable(hw_load_enable_chan_o))
      else $error("mask changed");
   load_on_a: assert property (output_load_strobe_i |=>
      ((output_code_o ^ $past(channel_code_register_i)) & $past(en)) == 128'h0)
      else $error("enabled channel not loaded");
   load_off_a: assert property (output_load_strobe_i |=>
      ((output_code_o ^ $past(output_code_o)) & ~$past(en)) == 128'h0)
      else $error("disabled channel loaded");
   if_err_a: assert property (rs && e && $past(e) |=> reg_rdata_o[1])
      else $error("interface error not flagged");
   clear_one_a: assert property (ws && reg_wdata_i[1] && !e ##1 !e ##1 rs
      |=> !reg_rdata_o[1])
      else $error("flag not cleared");
   cover property (rs);
   cover property (ws && e);
   cover property (wm);
   cover property (output_load_strobe_i);
endmodule
bind dsl_top dsl_top_monitor chk(.*);

// [test/test_dac_status_and_hw_load_enable.sv]
// Purpose: Directed test of the status and load mask registers
// Assumes: 125 MHz clock, 80-cycle update gap
// Notes: Register traffic goes through the host model
`timescale 1ns/100ps
module test_dac_status_and_hw_load_enable;
   logic clk_i, rst_i, wr, rd, ld;
   logic [7:0] addr, wdata, rdata, upd, err, mask;
   logic [127:0] code, outc, exp;
   int err_total, check_count;
   dsl_top uut(.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .if_err_flags_i(err), .chan_update_i(upd),
      .output_load_strobe_i(ld), .channel_code_register_i(code), .output_code_o(outc),
      .hw_load_enable_chan_o(mask));
   dsl_host_model host(.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
      check_count++;
      if (s !== e)
      begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      host.rd(a, v);
      chk("reg", 128'(e), 128'(v));
   endtask
   // Two update pulses, gap cycles apart
   task automatic twice(input int gap);
      @(posedge clk_i) upd <= 8'h01;
      @(posedge clk_i) upd <= 8'h00;
      repeat (gap - 1) @(posedge clk_i);
      upd <= 8'h80;
      @(posedge clk_i) upd <= 8'h00;
   endtask
   // One load pin pulse, outputs settled when it returns
   task automatic pulse_load;
      @(posedge clk_i) ld <= 1'b1;
      @(posedge clk_i) ld <= 1'b0;
      @(posedge clk_i);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Run is about 450 cycles
   initial
   begin
      #20us;
      err_total++;
      print_verdict;
   end
   initial
   begin
      {rst_i, ld, upd, err} = {1'b1, 1'b0, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++)
         code[16*i+:16] = 16'hA000 + 16'(i);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(8'hC2, 8'h04);
      rc(8'hD0, 8'hFF);
      rc(8'h55, 8'h00);
      host.wr(8'hC2, 8'hFF);
      rc(8'hC2, 8'h00);
      host.wr(8'hD0, 8'hA5);
      rc(8'hD0, 8'hA5);
      chk("mask", 128'(8'hA5), 128'(mask));
      pulse_load();
      for (int i = 0; i < 8; i++)
         exp[16*i+:16] = ((8'hA5 >> i) & 8'h01) != 8'h00 ? code[16*i+:16] : 16'h0000;
      chk("codes", exp, outc);
      repeat (100) @(posedge clk_i);
      twice(79);
      rc(8'hC2, 8'h08);
      host.wr(8'hC2, 8'h08);
      repeat (100) @(posedge clk_i);
      twice(80);
      rc(8'hC2, 8'h00);
      @(posedge clk_i) err <= 8'h10;
      repeat (3) @(posedge clk_i);
      rc(8'hC2, 8'h02);
      // A clear while the error is still high loses to the set
      host.wr(8'hC2, 8'h02);
      rc(8'hC2, 8'h02);
      err <= 8'h00;
      rc(8'hC2, 8'h02);
      host.wr(8'hC2, 8'h02);
      rc(8'hC2, 8'h00);
      // Reset in mid-run raises the warning again and restores the mask
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(8'hC2, 8'h04);
      rc(8'hD0, 8'hFF);
      pulse_load();
      chk("codes", code, outc);
      print_verdict;
   end
endmodule
